// File: logic/pfc_cfg.svh
// constants of the parallel flash host controller
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_CLK_NS 40
`define PFC_ADDR_W 22
`define PFC_DATA_W 16
`define PFC_BANK_LSB 19
`define PFC_BANK_W 2
`define PFC_UNLOCK1_ADDR 22'h000555
`define PFC_UNLOCK2_ADDR 22'h0002aa
`define PFC_UNLOCK1_DATA 16'h00aa
`define PFC_UNLOCK2_DATA 16'h0055
`define PFC_ACCESS_NS 70
`define PFC_WRITE_PULSE_NS 35
`define PFC_WRITE_HIGH_NS 30
`define PFC_RESET_PULSE_NS 500
`define PFC_RESET_HIGH_NS 50
`define PFC_READY_NS 20000
`define PFC_CYC_MIN(ns) (((ns) + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_MAX(ns) ((ns) < `PFC_CLK_NS ? 1 : (ns) / `PFC_CLK_NS)
`endif

// File: logic/pfc_pkg.sv
// types of the parallel flash host controller
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_OP_READ,
    PFC_OP_WRITE,
    PFC_OP_PROGRAM,
    PFC_OP_RESET
  } pfc_op_t;

  typedef struct packed {
    pfc_op_t op;
    logic [21:0] addr;
    logic [15:0] data;
    logic byte_lsb;
  } pfc_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic write_n;
    logic reset_n;
  } pfc_ctl_t;
endpackage : pfc_pkg

// File: logic/pfc_timer.sv
// down counter that flags when a programmed wait has elapsed
`timescale 1ns/1ps
module pfc_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] count,
  output logic done
);
  logic [15:0] cnt_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // done must not depend on load: the caller derives load from done
  assign done = (cnt_reg == 16'h0000);
endmodule : pfc_timer

// File: logic/pfc_host.sv
// host side controller that drives a parallel nor flash through its pins
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_host
  import pfc_pkg::*;
#(
  parameter int READY_CYC = `PFC_CYC_MIN(`PFC_READY_NS)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire pfc_req_t req,
  input wire logic byte_mode,
  input wire logic accel_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic busy,
  output pfc_ctl_t ctl,
  output logic [21:0] addr_out,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic [15:0] data_in,
  input wire logic ready_busy_n,
  output logic width_sel,
  output logic protect_accel_pin,
  output logic accel_high_voltage
);
  // all waits scale from configurable times
  localparam int ACC_CYC = `PFC_CYC_MIN(`PFC_ACCESS_NS);
  localparam int WP_CYC = `PFC_CYC_MIN(`PFC_WRITE_PULSE_NS);
  localparam int WH_CYC = `PFC_CYC_MIN(`PFC_WRITE_HIGH_NS);
  localparam int RP_CYC = `PFC_CYC_MIN(`PFC_RESET_PULSE_NS);
  localparam int RH_CYC = `PFC_CYC_MIN(`PFC_RESET_HIGH_NS);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WLOW,
    ST_WHIGH,
    ST_RLOW,
    ST_RWAIT,
    ST_RHIGH
  } pfc_state_t;

  pfc_state_t state_reg;
  pfc_req_t cur_reg;
  logic [1:0] step_reg;
  logic [1:0] rb_meta_reg;
  logic [15:0] din_meta_reg;
  logic [15:0] din_reg;
  logic t_load;
  logic [15:0] t_count;
  logic t_done;
  logic rb_sync;
  logic [37:0] first_word, next_word;

  function automatic logic [15:0] cyc16(input int n);
    cyc16 = n[15:0];
  endfunction : cyc16

  // picks the word put on the bus for each write cycle of a sequence
  function automatic logic [37:0] seq_word(input pfc_req_t r, input logic [1:0] s);
    logic [37:0] w;
    w = {r.addr, r.data};
    if (r.op == PFC_OP_PROGRAM && s == 2'd0) w = {`PFC_UNLOCK1_ADDR, `PFC_UNLOCK1_DATA};
    if (r.op == PFC_OP_PROGRAM && s == 2'd1) w = {`PFC_UNLOCK2_ADDR, `PFC_UNLOCK2_DATA};
    return w;
  endfunction : seq_word

  pfc_timer u_timer (
    .clock(clock),
    .rst(rst),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  // words go out in order: unlock pair first unless accelerated, then the user word
  assign next_word = seq_word(cur_reg, 2'd0 - step_reg);
  assign first_word = seq_word(req, accel_req ? 2'd2 : 2'd0);

  // pin inputs pass two flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rb_meta_reg <= 2'b11;
      din_meta_reg <= 16'h0000;
      din_reg <= 16'h0000;
    end else begin
      rb_meta_reg <= {rb_meta_reg[0], ready_busy_n};
      din_meta_reg <= data_in;
      din_reg <= din_meta_reg;
    end
  end
  assign rb_sync = rb_meta_reg[1];

  always_comb begin
    t_load = 1'b0;
    t_count = 16'h0000;
    if (state_reg == ST_IDLE && req_valid) begin
      t_load = 1'b1;
      case (req.op)
        PFC_OP_READ: t_count = cyc16(ACC_CYC + 2);
        PFC_OP_RESET: t_count = cyc16(RP_CYC);
        default: t_count = cyc16(WP_CYC);
      endcase
    // recovery is counted once ready returns or the wait runs out
    end else if (state_reg == ST_RWAIT && (t_done || rb_sync)) begin
      t_load = 1'b1;
      t_count = cyc16(RH_CYC);
    end else if (t_done) begin
      case (state_reg)
        ST_WLOW: begin
          t_load = 1'b1;
          t_count = cyc16(WH_CYC);
        end
        ST_WHIGH: begin
          t_load = (step_reg != 2'd0);
          t_count = cyc16(WP_CYC);
        end
        ST_RLOW: begin
          t_load = 1'b1;
          t_count = cyc16(READY_CYC);
        end
        default: t_count = 16'h0000;
      endcase
    end
  end

  // sequencer for reads, command writes and hardware reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      step_reg <= 2'd0;
    end else begin
      case (state_reg)
        ST_IDLE: if (req_valid) begin
          cur_reg <= req;
          case (req.op)
            PFC_OP_READ: state_reg <= ST_READ;
            PFC_OP_RESET: state_reg <= ST_RLOW;
            // program: unlock pair then program pair; with acceleration the program pair only
            PFC_OP_PROGRAM: begin
              step_reg <= accel_req ? 2'd1 : 2'd3;
              state_reg <= ST_WLOW;
            end
            default: begin
              step_reg <= 2'd0;
              state_reg <= ST_WLOW;
            end
          endcase
        end
        ST_READ: if (t_done) state_reg <= ST_IDLE;
        ST_WLOW: if (t_done) state_reg <= ST_WHIGH;
        ST_WHIGH: if (t_done) begin
          if (step_reg == 2'd0) begin
            state_reg <= ST_IDLE;
          end else begin
            step_reg <= step_reg - 2'd1;
            state_reg <= ST_WLOW;
          end
        end
        ST_RLOW: if (t_done) state_reg <= ST_RWAIT;
        // wait for ready, or for the ready wait to run out, before counting recovery
        ST_RWAIT: if (t_done || rb_sync) state_reg <= ST_RHIGH;
        // after recovery the host may reissue interrupted work
        ST_RHIGH: if (t_done) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // pin drive, all from flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1, reset_n: 1'b0};
      addr_out <= 22'h000000;
      data_out <= 16'h0000;
      data_oe <= 16'h0000;
      width_sel <= 1'b1;
      protect_accel_pin <= 1'b1;
      accel_high_voltage <= 1'b0;
      req_ready <= 1'b0;
      busy <= 1'b1;
    end else begin
      // protect pin always driven; high voltage only with acceleration
      protect_accel_pin <= 1'b1;
      // acceleration puts the flash into bypass programming
      accel_high_voltage <= accel_req;
      // width select follows the requested mode
      width_sel <= !byte_mode;
      req_ready <= (state_reg == ST_IDLE) && !req_valid && !req_ready;
      busy <= !((state_reg == ST_IDLE) && !req_valid);
      ctl.reset_n <= !(state_reg == ST_RLOW && !t_done) && !(state_reg == ST_IDLE && req_valid &&
        req.op == PFC_OP_RESET);
      // read: select and gate low, write strobe high
      ctl.out_gate_n <= !((state_reg == ST_IDLE && req_valid && req.op == PFC_OP_READ) ||
        (state_reg == ST_READ && !t_done));
      // write: strobe and select low, gate high
      ctl.write_n <= !((state_reg == ST_WHIGH && t_done && step_reg != 2'd0) ||
        (state_reg == ST_WLOW && !t_done) ||
        (state_reg == ST_IDLE && req_valid && req.op != PFC_OP_READ && req.op != PFC_OP_RESET));
      // select dropped outside accesses lets the flash stand by
      ctl.chip_sel_n <= !((state_reg == ST_READ && !t_done) || state_reg == ST_WLOW ||
        (state_reg == ST_WHIGH && !(t_done && step_reg == 2'd0)) ||
        (state_reg == ST_IDLE && req_valid && req.op != PFC_OP_RESET));
      if (state_reg == ST_IDLE && req_valid) begin
        addr_out <= req.addr;
        data_out <= req.data;
      end else if (state_reg == ST_WHIGH && t_done && step_reg != 2'd0) begin
        addr_out <= next_word[37:16];
        data_out <= next_word[15:0];
      end
      if (state_reg == ST_IDLE && req_valid && req.op == PFC_OP_PROGRAM) begin
        addr_out <= first_word[37:16];
        data_out <= first_word[15:0];
      end
      // byte mode: line fifteen is the low address bit, lines 14..8 idle
      if (byte_mode) begin
        data_out[15] <= (state_reg == ST_IDLE) ? req.byte_lsb : cur_reg.byte_lsb;
      end
      if (state_reg == ST_IDLE && req_valid && req.op != PFC_OP_READ && req.op != PFC_OP_RESET) begin
        data_oe <= byte_mode ? 16'h80ff : 16'hffff;
      end else if (state_reg == ST_IDLE && req_valid && req.op == PFC_OP_READ) begin
        data_oe <= byte_mode ? 16'h8000 : 16'h0000;
      end else if ((state_reg == ST_WHIGH && t_done && step_reg == 2'd0) ||
                   (state_reg == ST_READ && t_done)) begin
        data_oe <= 16'h0000;
      end
    end
  end

  // read data returns after the access time plus synchroniser delay
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= (state_reg == ST_READ) && t_done;
      if ((state_reg == ST_READ) && t_done) begin
        rsp_data <= byte_mode ? {8'h00, din_reg[7:0]} : din_reg;
      end
    end
  end

  // every read waits the full select access time
  property p_read_wait;
    @(posedge clock) disable iff (rst)
    $rose(state_reg == ST_READ) |-> !rsp_valid [*2];
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answered too early");

  property p_read_pins;
    @(posedge clock) disable iff (rst)
    !ctl.out_gate_n |-> !ctl.chip_sel_n && ctl.write_n;
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("bad read pin levels");

  property p_write_pins;
    @(posedge clock) disable iff (rst)
    !ctl.write_n |-> !ctl.chip_sel_n && ctl.out_gate_n;
  endproperty
  a_write_pins: assert property (p_write_pins) else $error("bad write pin levels");

  sequence s_reset_start;
    $fell(ctl.reset_n);
  endsequence
  property p_reset_width;
    @(posedge clock) disable iff (rst)
    s_reset_start |-> !ctl.reset_n [*8];
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

  property p_no_access_in_reset;
    @(posedge clock) disable iff (rst)
    !ctl.reset_n |-> ctl.chip_sel_n;
  endproperty
  a_no_access_in_reset: assert property (p_no_access_in_reset) else $error("access in reset");

  property p_accel_only;
    @(posedge clock) disable iff (rst)
    accel_high_voltage |-> protect_accel_pin && $past(accel_req);
  endproperty
  a_accel_only: assert property (p_accel_only) else $error("high voltage on low pin");

  property p_width;
    @(posedge clock) disable iff (rst)
    ##1 width_sel == !$past(byte_mode);
  endproperty
  a_width: assert property (p_width) else $error("width select wrong");

  property p_byte_hi_idle;
    @(posedge clock) disable iff (rst)
    (!width_sel && state_reg != ST_IDLE) |-> data_oe[14:8] == 7'h00;
  endproperty
  a_byte_hi_idle: assert property (p_byte_hi_idle) else $error("upper lines driven");
endmodule : pfc_host

// File: test/pfc_flash_model.sv
// behavioural parallel nor flash that answers the host controller pins
`timescale 1ns/1ps
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int BUSY_CYC = 8,
  parameter int RDY_CYC = 5
) (
  input wire logic clock,
  input wire pfc_ctl_t ctl,
  input wire logic [21:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic width_sel,
  input wire logic protect_accel_pin,
  input wire logic accel_high_voltage,
  output logic [15:0] data_in,
  output logic ready_busy_n
);
  logic [15:0] mem [0:255];
  logic [15:0] last_v;
  logic [15:0] fen;
  logic [15:0] fval;
  logic [15:0] word;
  logic rd_on;
  int nwr;
  int err;
  int busy_left;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0] ^ 8'h5a, i[7:0]};
    end
    nwr = 0;
    err = 0;
    busy_left = 0;
    last_v = 16'h0000;
  end
  // outputs driven only when selected, gated and out of reset
  assign rd_on = !ctl.chip_sel_n && !ctl.out_gate_n && ctl.reset_n;
  // data follows the address at once, held while it stays put
  assign word = mem[addr_out[7:0]];
  // word drives all lines, byte drives the low lines only
  assign fen = rd_on ? (width_sel ? 16'hffff : 16'h00ff) : 16'h0000;
  assign fval = width_sel ? word : {8'h00, data_out[15] ? word[15:8] : word[7:0]};
  // undriven lines show the inverse of their last level
  assign data_in = (data_oe & data_out) | (~data_oe & fen & fval) | (~data_oe & ~fen & ~last_v);
  assign ready_busy_n = (busy_left == 0);
  always @(posedge clock) begin
    last_v <= data_in;
    // operation runs on whatever the select does
    if (busy_left > 0) busy_left <= busy_left - 1;
    if (protect_accel_pin !== 1'b1) err++;
  end
  // write cycles counted, data word stored except at the two unlock addresses
  always @(posedge ctl.write_n) begin
    if (!ctl.chip_sel_n && ctl.reset_n) begin
      nwr++;
      if (addr_out != 22'h000555 && addr_out != 22'h0002aa) begin
        mem[addr_out[7:0]] = data_out;
        busy_left = BUSY_CYC;
      end
    end
  end
  // reset keeps ready low until internal reset ends
  always @(negedge ctl.reset_n) busy_left = RDY_CYC;
  always @(negedge ctl.write_n) if (!ctl.chip_sel_n && !ctl.out_gate_n) err++;
  always @(negedge ctl.out_gate_n) if (!ctl.chip_sel_n && !ctl.write_n) err++;
endmodule : pfc_flash_model

// File: test/pfc_host_bench.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
module pfc_host_bench;
  import pfc_pkg::*;
  logic clock, rst, req_valid, byte_mode, accel_req, req_ready, rsp_valid, busy;
  logic ready_busy_n, width_sel, protect_accel_pin, accel_high_voltage;
  pfc_req_t req;
  pfc_ctl_t ctl;
  logic [21:0] addr_out;
  logic [15:0] rsp_data, data_out, data_oe, data_in, got;
  int failures, tests_run, n0;
  pfc_host #(.READY_CYC(10)) dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .byte_mode(byte_mode), .accel_req(accel_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .ctl(ctl), .addr_out(addr_out),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ready_busy_n(ready_busy_n),
    .width_sel(width_sel), .protect_accel_pin(protect_accel_pin),
    .accel_high_voltage(accel_high_voltage));
  pfc_flash_model flash (.clock(clock), .ctl(ctl), .addr_out(addr_out), .data_out(data_out),
    .data_oe(data_oe), .width_sel(width_sel), .protect_accel_pin(protect_accel_pin),
    .accel_high_voltage(accel_high_voltage), .data_in(data_in), .ready_busy_n(ready_busy_n));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 300) begin
      @(posedge clock);
      #1;
      if (rsp_valid === 1'b1) got = rsp_data;
      n++;
    end
    if (busy !== lvl) begin
      failures++;
      $display("unexpected busy expected %b seen %b", lvl, busy);
      wrap_up();
    end
  endtask : wait_busy
  task automatic do_req(input pfc_op_t op, input logic [21:0] a, input logic [15:0] d,
      input logic lsb);
    @(posedge clock);
    #1;
    req = '{op: op, addr: a, data: d, byte_lsb: lsb};
    req_valid = 1'b1;
    got = 16'hxxxx;
    wait_busy(1'b1);
    req_valid = 1'b0;
    wait_busy(1'b0);
  endtask : do_req
  task automatic t_word_read();
    do_req(PFC_OP_READ, 22'h000012, 16'h0000, 1'b0);
    check("word read", 16'h4812, got);
    check("width pin", 16'h0001, {15'h0000, width_sel});
  endtask : t_word_read
  task automatic t_byte_read();
    byte_mode = 1'b1;
    do_req(PFC_OP_READ, 22'h000034, 16'h0000, 1'b1);
    check("byte high", 16'h006e, {8'h00, got[7:0]});
    do_req(PFC_OP_READ, 22'h000034, 16'h0000, 1'b0);
    check("byte low", 16'h0034, {8'h00, got[7:0]});
    check("width pin", 16'h0000, {15'h0000, width_sel});
    byte_mode = 1'b0;
  endtask : t_byte_read
  task automatic t_write();
    n0 = flash.nwr;
    do_req(PFC_OP_WRITE, 22'h000555, 16'h00aa, 1'b0);
    check("write cycles", 16'h0001, 16'(flash.nwr - n0));
    check("idle ready", 16'h0001, {15'h0000, req_ready});
  endtask : t_write
  task automatic t_program(input logic acc, input logic [15:0] n_exp, input logic [21:0] a,
      input logic [15:0] d);
    accel_req = acc;
    n0 = flash.nwr;
    do_req(PFC_OP_PROGRAM, a, d, 1'b0);
    check("program cycles", n_exp, 16'(flash.nwr - n0));
    check("high voltage", {15'h0000, acc}, {15'h0000, accel_high_voltage});
    accel_req = 1'b0;
    do_req(PFC_OP_READ, a, 16'h0000, 1'b0);
    check("read back", d, got);
  endtask : t_program
  task automatic t_reset_busy();
    do_req(PFC_OP_PROGRAM, 22'h000041, 16'hbeef, 1'b0);
    do_req(PFC_OP_RESET, 22'h000000, 16'h0000, 1'b0);
    check("ready after reset", 16'h0001, {15'h0000, ready_busy_n});
    do_req(PFC_OP_READ, 22'h000020, 16'h0000, 1'b0);
    check("array after reset", 16'h7a20, got);
    do_req(PFC_OP_PROGRAM, 22'h000041, 16'hbeef, 1'b0);
    do_req(PFC_OP_READ, 22'h000041, 16'h0000, 1'b0);
    check("reissued program", 16'hbeef, got);
  endtask : t_reset_busy
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    byte_mode = 1'b0;
    accel_req = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    t_word_read();
    t_byte_read();
    t_write();
    t_program(1'b0, 16'h0004, 22'h000077, 16'h1234);
    t_program(1'b1, 16'h0002, 22'h000078, 16'hc3a5);
    t_reset_busy();
    check("pin discipline", 16'h0000, 16'(flash.err));
    wrap_up();
  end
endmodule : pfc_host_bench
